// ### retention_monitor_params.svh
// Constants for the retention monitor block
`ifndef RETENTION_MONITOR_PARAMS_SVH
`define RETENTION_MONITOR_PARAMS_SVH
// Flag encodings
`define FLAG_NO 8'h5B
`define FLAG_YES 8'hAD
// Source state codes
`define SRC_LIVE 3'h1
`define SRC_FILE 3'h2
`define SRC_COPY 3'h3
`define SRC_INVALID 3'h4
// Status change event detail
`define EVT_ID 8'hCD
`define EVT_DETAIL 32'h00000040
`endif

// ### retention_monitor_pkg.sv
// Types for the retention monitor block
package retention_monitor_pkg;
    typedef enum logic [1:0] {
        NEED_REQUIRED = 2'b00,
        NEED_OPTIONAL = 2'b01,
        NEED_CLOCK_ONLY = 2'b10,
        NEED_NOT_REQUIRED = 2'b11
    } battery_need_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EVAL = 2'b01,
        ST_DONE = 2'b10
    } phase_t;
    // Power-up conditions sampled from the supervisor
    typedef struct packed {
        logic backup_low;
        logic clock_lost;
        logic checksum_bad;
        logic live_valid;
        logic file_valid;
        logic copy_valid;
    } powerup_cond_t;
    // Battery sense inputs
    typedef struct packed {
        logic module_fitted;
        logic battery_fitted;
        logic below_level1;
        logic below_level2;
    } battery_sense_t;
endpackage

// ### backup_power_status_monitor.sv
// Backup power and retained data status monitor
// Function
// - At power-up the backup-voltage flag becomes YES (173) if backup voltage was low, else NO (91).
// - A YES backup-voltage flag stays YES until software writes NO.
// - A YES backup-voltage flag requests reload of retained data from the memory card.
// - The clock-invalid flag is evaluated once at power-up and set YES if clock contents were lost.
// - The checksum flag is evaluated once at power-up and set YES on a retained-data checksum error.
// - Clock-invalid and checksum flags stay YES until software clears them and survive power cycles.
// - At power-up the source state records live (1), file (2), copy (3) or invalid (4).
// - An invalid source state loads default settings into retained data.
// - The prewarning flag follows its condition and stays set while below level 2.
// - The warning flag follows the battery crossing level 2 in both directions.
// - Both warnings are set for a low fitted battery, a module without battery, or no module.
// - The battery need class is one of required, optional, clock-only optional or not required.
// - Battery is present only for the first three classes with module and battery fitted, else absent.
// - For clock-only and not-required classes the clock rides only on the backup capacitor.
// - A battery status change in run mode after power-up, with module and battery fitted, raises an event with id 205 and detail 0x40.
`timescale 1ns/1ps
`include "retention_monitor_params.svh"

module backup_power_status_monitor #(
    parameter logic [1:0] NEED_CLASS = 2'h1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic powerup_start,
    input wire retention_monitor_pkg::powerup_cond_t cond_pin,
    input wire retention_monitor_pkg::battery_sense_t sense_pin,
    input wire logic [7:0] nv_clock_flag,
    input wire logic [7:0] nv_checksum_flag,
    input wire logic run_mode,
    input wire logic wr_backup_flag,
    input wire logic wr_clock_flag,
    input wire logic wr_checksum_flag,
    input wire logic [7:0] wr_data,
    output logic [7:0] backup_voltage_fail_flag,
    output logic [7:0] clock_invalid_flag,
    output logic [7:0] retained_checksum_flag,
    output logic [2:0] retained_source_state,
    output logic battery_prewarn_flag,
    output logic battery_warn_flag,
    output retention_monitor_pkg::battery_need_t battery_need,
    output logic battery_present,
    output logic card_reload_req,
    output logic load_defaults,
    output logic clock_capacitor_only,
    output logic powerup_done,
    output logic event_valid,
    output logic [7:0] event_id,
    output logic [31:0] event_detail
);
    import retention_monitor_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins are asynchronous; two stages before any logic looks at them
    powerup_cond_t cond_s1_ff, cond_ff;
    battery_sense_t sense_s1_ff, sense_ff;
    logic start_s1_ff, start_ff;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cond_s1_ff <= '0;
            cond_ff <= '0;
            sense_s1_ff <= '0;
            sense_ff <= '0;
            start_s1_ff <= 1'b0;
            start_ff <= 1'b0;
        end
        else
        begin
            cond_s1_ff <= cond_pin;
            cond_ff <= cond_s1_ff;
            sense_s1_ff <= sense_pin;
            sense_ff <= sense_s1_ff;
            start_s1_ff <= powerup_start;
            start_ff <= start_s1_ff;
        end
    end

    // ----------------------------------------
    // Power-up evaluation and sticky flags
    // ----------------------------------------
    phase_t phase_ff, nxt_phase;
    logic [7:0] bv_ff, nxt_bv, ck_ff, nxt_ck, cs_ff, nxt_cs;
    logic [2:0] src_ff, nxt_src;
    logic evaluating;
    assign evaluating = (phase_ff == ST_EVAL);

    // Evaluation happens in one cycle; a write in that cycle loses to it
    always_comb
    begin
        nxt_phase = phase_ff;
        nxt_bv = bv_ff;
        nxt_ck = ck_ff;
        nxt_cs = cs_ff;
        nxt_src = src_ff;
        case (phase_ff)
            ST_IDLE:
                if (start_ff)
                    nxt_phase = ST_EVAL;
            ST_EVAL:
            begin
                nxt_bv = cond_ff.backup_low ? `FLAG_YES : `FLAG_NO;
                // Carried-over values model retention across power cycles
                nxt_ck = (cond_ff.clock_lost || nv_clock_flag == `FLAG_YES)
                    ? `FLAG_YES : `FLAG_NO;
                nxt_cs = (cond_ff.checksum_bad || nv_checksum_flag == `FLAG_YES)
                    ? `FLAG_YES : `FLAG_NO;
                if (cond_ff.live_valid)
                    nxt_src = `SRC_LIVE;
                else if (cond_ff.file_valid)
                    nxt_src = `SRC_FILE;
                else if (cond_ff.copy_valid)
                    nxt_src = `SRC_COPY;
                else
                    nxt_src = `SRC_INVALID;
                nxt_phase = ST_DONE;
            end
            default:
            begin
                // Only the exact NO code clears; set cannot occur here
                if (wr_backup_flag && wr_data == `FLAG_NO)
                    nxt_bv = `FLAG_NO;
                if (wr_clock_flag && wr_data == `FLAG_NO)
                    nxt_ck = `FLAG_NO;
                if (wr_checksum_flag && wr_data == `FLAG_NO)
                    nxt_cs = `FLAG_NO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_ff <= ST_IDLE;
            bv_ff <= `FLAG_NO;
            ck_ff <= `FLAG_NO;
            cs_ff <= `FLAG_NO;
            src_ff <= `SRC_LIVE;
        end
        else
        begin
            phase_ff <= nxt_phase;
            bv_ff <= nxt_bv;
            ck_ff <= nxt_ck;
            cs_ff <= nxt_cs;
            src_ff <= nxt_src;
        end
    end

    // ----------------------------------------
    // Battery warnings and events
    // ----------------------------------------
    logic pre_ff, nxt_pre, warn_ff, nxt_warn;
    logic evt_ff, nxt_evt;
    logic no_battery, pre_cond, warn_cond;
    assign no_battery = !sense_ff.module_fitted || !sense_ff.battery_fitted;
    assign warn_cond = no_battery || sense_ff.below_level2;
    assign pre_cond = warn_cond || sense_ff.below_level1;

    // Flags track their conditions; an event fires on any change in run mode after power-up unless no battery is fitted
    always_comb
    begin
        nxt_pre = pre_cond;
        nxt_warn = warn_cond;
        // No fitted battery means no status event at all
        nxt_evt = run_mode && (phase_ff == ST_DONE) && !no_battery
            && ((pre_cond != pre_ff) || (warn_cond != warn_ff));
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_ff <= 1'b0;
            warn_ff <= 1'b0;
            evt_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= nxt_pre;
            warn_ff <= nxt_warn;
            evt_ff <= nxt_evt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign backup_voltage_fail_flag = bv_ff;
    assign clock_invalid_flag = ck_ff;
    assign retained_checksum_flag = cs_ff;
    assign retained_source_state = src_ff;
    assign battery_prewarn_flag = pre_ff;
    assign battery_warn_flag = warn_ff;
    assign battery_need = battery_need_t'(NEED_CLASS);
    assign battery_present = (battery_need != NEED_NOT_REQUIRED)
        && sense_ff.module_fitted && sense_ff.battery_fitted;
    assign card_reload_req = (phase_ff == ST_DONE) && (bv_ff == `FLAG_YES);
    assign load_defaults = (phase_ff == ST_DONE) && (src_ff == `SRC_INVALID);
    assign clock_capacitor_only = (battery_need == NEED_CLOCK_ONLY)
        || (battery_need == NEED_NOT_REQUIRED);
    assign powerup_done = (phase_ff == ST_DONE);
    assign event_valid = evt_ff;
    assign event_id = `EVT_ID;
    assign event_detail = `EVT_DETAIL;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_bv_eval: assert property (@(posedge clk) disable iff (!rst_n)
        evaluating |=> bv_ff == ($past(cond_ff.backup_low) ? 8'hAD : 8'h5B))
        else $error("backup flag not evaluated");
    a_bv_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (phase_ff == ST_DONE && bv_ff == 8'hAD && !(wr_backup_flag && wr_data == 8'h5B))
        |=> bv_ff == 8'hAD)
        else $error("backup flag dropped");
    a_reload_req: assert property (@(posedge clk) disable iff (!rst_n)
        (powerup_done && bv_ff == 8'hAD) |-> card_reload_req)
        else $error("reload not requested");
    a_ck_eval: assert property (@(posedge clk) disable iff (!rst_n)
        (evaluating && cond_ff.clock_lost) |=> ck_ff == 8'hAD)
        else $error("clock flag not set");
    a_cs_eval: assert property (@(posedge clk) disable iff (!rst_n)
        (evaluating && cond_ff.checksum_bad) |=> cs_ff == 8'hAD)
        else $error("checksum flag not set");
    a_ck_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (powerup_done && ck_ff == 8'hAD && !wr_clock_flag) |=> ck_ff == 8'hAD)
        else $error("clock flag dropped");
    a_src_invalid: assert property (@(posedge clk) disable iff (!rst_n)
        (evaluating && !cond_ff.live_valid && !cond_ff.file_valid && !cond_ff.copy_valid)
        |=> src_ff == 3'h4 && load_defaults)
        else $error("invalid source not recorded");
    a_pre_hold: assert property (@(posedge clk) disable iff (!rst_n)
        warn_ff |-> pre_ff)
        else $error("prewarn cleared below level 2");
    a_warn_track: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sense_ff.below_level2) |=> warn_ff)
        else $error("warn missed crossing");
    a_no_module: assert property (@(posedge clk) disable iff (!rst_n)
        !sense_ff.module_fitted |=> warn_ff && pre_ff)
        else $error("warnings not set without module");
    a_present: assert property (@(posedge clk) disable iff (!rst_n)
        battery_present |-> sense_ff.battery_fitted && battery_need != NEED_NOT_REQUIRED)
        else $error("battery present wrongly");
    a_clear_other: assert property (@(posedge clk) disable iff (!rst_n)
        (powerup_done && wr_checksum_flag && wr_data != 8'h5B) |=> $stable(cs_ff))
        else $error("flag changed by non-NO write");
endmodule // backup_power_status_monitor

// ### testbench.sv
// Self-checking bench for the backup power status monitor
`timescale 1ns/1ps
`include "retention_monitor_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end

module testbench;
    import retention_monitor_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic powerup_start = 1'b0;
    powerup_cond_t cond_pin = '0;
    battery_sense_t sense_pin = 4'hC;
    logic [7:0] nv_clock_flag = `FLAG_NO;
    logic [7:0] nv_checksum_flag = `FLAG_NO;
    logic run_mode = 1'b0;
    logic [2:0] wr_sel = 3'h0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] backup_voltage_fail_flag, clock_invalid_flag, retained_checksum_flag, event_id;
    logic [2:0] retained_source_state;
    logic battery_prewarn_flag, battery_warn_flag, battery_present, card_reload_req;
    logic load_defaults, clock_capacitor_only, powerup_done, event_valid;
    battery_need_t battery_need;
    logic [31:0] event_detail;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_evt = 0;
    int cyc = 0;
    int sel_q[$];
    logic [31:0] exp_q[$];
    int cur_sel = 0;
    logic [31:0] cur_exp = 32'h0;
    logic [31:0] rnd = 32'h0000BBE8;
    // Battery steps: sense, expected {prewarn, warn, present}, event count
    logic [3:0] sv [8] = '{4'hC, 4'hE, 4'hF, 4'hE, 4'hC, 4'hE, 4'h8, 4'h0};
    logic [2:0] fv [8] = '{3'h1, 3'h5, 3'h7, 3'h5, 3'h1, 3'h5, 3'h6, 3'h6};
    int nv [8] = '{0, 1, 2, 3, 4, 4, 4, 4};

    backup_power_status_monitor #(.NEED_CLASS(2'h1)) uut (.*, .wr_backup_flag(wr_sel[0]),
        .wr_clock_flag(wr_sel[1]), .wr_checksum_flag(wr_sel[2]));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    function automatic logic [7:0] yn(logic b);
        return b ? `FLAG_YES : `FLAG_NO;
    endfunction

    function automatic logic [31:0] obs(int s);
        case (s)
            0: return {24'h0, backup_voltage_fail_flag};
            1: return {24'h0, clock_invalid_flag};
            2: return {24'h0, retained_checksum_flag};
            3: return {29'h0, retained_source_state};
            4: return {29'h0, card_reload_req, load_defaults, powerup_done};
            5: return {29'h0, battery_prewarn_flag, battery_warn_flag, battery_present};
            6: return n_evt;
            7: return {24'h0, event_id};
            8: return event_detail;
            // Software view: checksum bad with backup voltage fine hints at a hardware fault
            10: return {31'h0, retained_checksum_flag == `FLAG_YES
                && backup_voltage_fail_flag == `FLAG_NO};
            default: return {29'h0, battery_need, clock_capacitor_only};
        endcase
    endfunction

    task automatic ex(int s, logic [31:0] e);
        sel_q.push_back(s);
        exp_q.push_back(e);
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask

    // One-cycle strobe; the release edge keeps back-to-back calls apart
    task automatic wr(logic [2:0] s, logic [7:0] d);
        @(posedge clk);
        wr_sel <= s;
        wr_data <= d;
        @(posedge clk);
        wr_sel <= 3'h0;
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, timeout, event count, monitor
    // ----------------------------------------
    initial
    begin
        forever #20 clk = ~clk;
    end

    // Whole run is well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    always @(posedge clk)
        if (event_valid === 1'b1)
            n_evt <= n_evt + 1;

    // Compare at the falling edge; pop first, as the macro reads its arguments twice
    always @(negedge clk)
        while (sel_q.size() > 0)
        begin
            cur_sel = sel_q.pop_front();
            cur_exp = exp_q.pop_front();
            `CHK(obs(cur_sel), cur_exp)
        end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] r;
        logic [7:0] v;
        logic [7:0] e [3];
        tick(16);
        // One evaluation per source case, random conditions alongside
        for (int i = 0; i < 4; i++)
        begin
            r = xs();
            rst_n <= 1'b0;
            powerup_start <= 1'b0;
            tick(2);
            rst_n <= 1'b1;
            cond_pin <= {r[2:0], 3'(4 >> i)};
            nv_clock_flag <= yn(r[3]);
            nv_checksum_flag <= yn(r[4]);
            tick(2);
            powerup_start <= 1'b1;
            tick(8);
            // Conditions drop after evaluation; flags must not follow
            cond_pin <= '0;
            tick(4);
            e = '{yn(r[2]), yn(r[1] | r[3]), yn(r[0] | r[4])};
            for (int j = 0; j < 3; j++) ex(j, e[j]);
            ex(3, i + 1);
            ex(4, {r[2], i == 3, 1'b1});
            ex(10, {31'h0, (r[0] | r[4]) & ~r[2]});
            v = 8'(xs());
            if (v == `FLAG_NO)
                v = `FLAG_YES;
            wr(3'h7, v);
            tick(1);
            for (int j = 0; j < 3; j++) ex(j, e[j]);
            wr(3'h1, `FLAG_NO);
            wr(3'h2, `FLAG_NO);
            wr(3'h4, `FLAG_NO);
            tick(1);
            for (int j = 0; j < 3; j++) ex(j, `FLAG_NO);
        end
        run_mode <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            if (k == 5)
                run_mode <= 1'b0;
            sense_pin <= sv[k];
            tick(6);
            ex(5, fv[k]);
            ex(6, nv[k]);
        end
        ex(7, `EVT_ID);
        ex(8, `EVT_DETAIL);
        ex(9, {NEED_OPTIONAL, 1'b0});
        tick(2);
        summarize();
    end
endmodule // testbench
